/* rtl/mrx_cfg.svh */
// register offsets, field positions, reset values and cycle counts of the move/return executor
// assumes a 32-bit classic wishbone slave with byte addresses, one word per register
`ifndef MRX_CFG_SVH
`define MRX_CFG_SVH

// byte offsets
`define MRX_OFF_CMD       8'h00
`define MRX_OFF_ACC       8'h04
`define MRX_OFF_PTR0      8'h08
`define MRX_OFF_PTR1      8'h0c
`define MRX_OFF_PRESCALE  8'h10
`define MRX_OFF_IRQCTL    8'h14
`define MRX_OFF_PWRCTL    8'h18
`define MRX_OFF_PC        8'h1c
`define MRX_OFF_STACK     8'h20
`define MRX_OFF_STATUS    8'h24

// command word fields
`define MRX_CMD_OP_LSB    0
`define MRX_CMD_F_LSB     3
`define MRX_CMD_N_BIT     10
`define MRX_CMD_MODE_LSB  11
`define MRX_CMD_K_LSB     13

// bit positions inside control registers
`define MRX_GIE_BIT       7
`define MRX_SRF_BIT       2

// reset values
`define MRX_RST_ACC       8'h00
`define MRX_RST_PTR       16'h0000
`define MRX_RST_PRESCALE  8'hff
`define MRX_RST_IRQCTL    8'h00
`define MRX_RST_PWRCTL    8'hff
`define MRX_RST_PC        15'h0000

// instruction cycle counts
`define MRX_CYC_SINGLE    1
`define MRX_CYC_RETURN    2

`endif

/* rtl/mrx_pkg.sv */
// types of the move/return executor: opcodes, pointer update modes, sequencer states
// assumes nothing beyond a systemverilog compiler
package mrx_pkg;

  // command opcodes, field op of the command word
  typedef enum logic [2:0] {
    MRX_OP_IDLE     = 3'h0,
    MRX_OP_TO_FILE  = 3'h1,
    MRX_OP_TO_IND   = 3'h2,
    MRX_OP_TO_REL   = 3'h3,
    MRX_OP_PRESCALE = 3'h4,
    MRX_OP_SOFT_RST = 3'h5,
    MRX_OP_RET_IRQ  = 3'h6,
    MRX_OP_RET_SUB  = 3'h7
  } mrx_op_t;

  // pointer_update_mode encodings
  typedef enum logic [1:0] {
    MRX_PRE_INC  = 2'b00,
    MRX_PRE_DEC  = 2'b01,
    MRX_POST_INC = 2'b10,
    MRX_POST_DEC = 2'b11
  } mrx_mode_t;

  // sequencer, gray along idle -> exec -> second cycle
  typedef enum logic [1:0] {
    MRX_ST_IDLE = 2'b00,
    MRX_ST_EXEC = 2'b01,
    MRX_ST_SEC  = 2'b11
  } mrx_state_t;

endpackage

/* rtl/mrx_ptr_if.sv */
// carrier between the executor and its pointer arithmetic unit
// assumes both ends sit in the same clock domain; purely combinational content
`timescale 1ns/1ns
interface mrx_ptr_if;
  import mrx_pkg::*;

  logic      [15:0] ptr;
  mrx_mode_t        mode;
  logic             rel;
  logic      [5:0]  k;
  logic      [15:0] ea;
  logic      [15:0] nxt;

  // arithmetic side
  modport calc (input ptr, input mode, input rel, input k, output ea, output nxt);
  // executor side
  modport user (output ptr, output mode, output rel, output k, input ea, input nxt);
endinterface

/* rtl/mrx_ptr_unit.sv */
// effective address and write-back value for the indirect store
// assumes the executor presents the selected pointer and operands for the whole cycle
`timescale 1ns/1ns
module mrx_ptr_unit
  import mrx_pkg::*;
(
  // pointer operands and results
  mrx_ptr_if.calc p
);

  wire [15:0] ptr_inc;
  wire [15:0] ptr_dec;
  wire [15:0] ptr_off;
  wire        is_inc;
  wire        is_pre;

  // 16-bit adders wrap modulo the pointer range by their width
  assign ptr_inc = p.ptr + 16'h0001;
  assign ptr_dec = p.ptr - 16'h0001;
  assign ptr_off = p.ptr + {{10{p.k[5]}}, p.k};

  // mode decode
  assign is_inc = (p.mode == MRX_PRE_INC) || (p.mode == MRX_POST_INC);
  assign is_pre = (p.mode == MRX_PRE_INC) || (p.mode == MRX_PRE_DEC);

  // pre modes address the adjusted value, post modes the old one
  assign p.ea  = p.rel ? ptr_off : (is_pre ? (is_inc ? ptr_inc : ptr_dec) : p.ptr);
  assign p.nxt = p.rel ? p.ptr : (is_inc ? ptr_inc : ptr_dec);

endmodule // mrx_ptr_unit

/* rtl/mrx_exec.sv */
// move / indirect store / return executor with a wishbone register port
// assumes a classic wishbone master on clk_i and a data memory that takes one write per cycle
//
// Behaviour
// - file move copies accumulator, flags untouched
// - indirect store through pointer 0 or 1
// - mode 00 preinc 01 predec 10 postinc 11 postdec
// - relative form: pointer plus -32..31, pointer kept
// - pre adjusts first, post after; value written back
// - pointers are 16 bits and wrap
// - pointer update and store touch no flags
// - idle instruction: one cycle, only pc advances
// - prescale load copies accumulator, one cycle
// - soft reset resets device, clears reset flag
// - irq return pops stack into pc, two cycles
// - irq return sets global enable, control bit 7
// - subroutine return pops into pc, two cycles
`timescale 1ns/1ns
`include "mrx_cfg.svh"
module mrx_exec
  import mrx_pkg::*;
#(
  parameter int PC_W        = 15,
  parameter int STACK_DEPTH = 16
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // data memory write port
  output logic                   mem_we_o,
  output logic      [15:0]       mem_adr_o,
  output logic      [7:0]        mem_dat_o,
  // core state seen by the rest of the chip
  output logic      [7:0]        prescale_o,
  output logic                   global_irq_enable_o,
  output logic      [PC_W-1:0]   pc_o,
  output logic                   soft_reset_o,
  output logic                   busy_o
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  // architectural state
  mrx_state_t        state_q, state_d;
  logic [31:0]       instr_q;
  logic [7:0]        acc_q;
  logic [15:0]       ptr_q [2];
  logic [7:0]        prescale_q;
  logic [7:0]        irq_control_reg_q;
  logic [7:0]        power_control_reg_q;
  logic [PC_W-1:0]   pc_q;
  logic [PC_W-1:0]   stack_q [STACK_DEPTH];
  logic [SP_W-1:0]   sp_q;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic              mem_we_q;
  logic [15:0]       mem_adr_q;
  logic [7:0]        mem_dat_q;
  logic              soft_reset_q;

  // command fields
  wire mrx_op_t      op;
  wire [6:0]         f_opnd;
  wire               n_sel;
  wire mrx_mode_t    mode;
  wire [5:0]         k_opnd;

  assign op     = mrx_op_t'(instr_q[`MRX_CMD_OP_LSB +: 3]);
  assign f_opnd = instr_q[`MRX_CMD_F_LSB +: 7];
  assign n_sel  = instr_q[`MRX_CMD_N_BIT];
  assign mode   = mrx_mode_t'(instr_q[`MRX_CMD_MODE_LSB +: 2]);
  assign k_opnd = instr_q[`MRX_CMD_K_LSB +: 6];

  // bus decode; a write lands at the edge on which ack is high
  wire        bus_req;
  wire        bus_wr;
  wire        wr_cmd;
  wire        wr_acc;
  wire        wr_ptr0;
  wire        wr_ptr1;
  wire        wr_pre;
  wire        wr_irq;
  wire        wr_pwr;
  wire        wr_pc;
  wire        wr_stk;
  wire        lane0;
  wire        lane1;

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr  = bus_req && wb_we_i && ack_q;
  assign lane0   = wb_sel_i[0];
  assign lane1   = wb_sel_i[1];
  assign wr_cmd  = bus_wr && (wb_adr_i == `MRX_OFF_CMD);
  assign wr_acc  = bus_wr && (wb_adr_i == `MRX_OFF_ACC) && lane0;
  assign wr_ptr0 = bus_wr && (wb_adr_i == `MRX_OFF_PTR0);
  assign wr_ptr1 = bus_wr && (wb_adr_i == `MRX_OFF_PTR1);
  assign wr_pre  = bus_wr && (wb_adr_i == `MRX_OFF_PRESCALE) && lane0;
  assign wr_irq  = bus_wr && (wb_adr_i == `MRX_OFF_IRQCTL) && lane0;
  assign wr_pwr  = bus_wr && (wb_adr_i == `MRX_OFF_PWRCTL) && lane0;
  assign wr_pc   = bus_wr && (wb_adr_i == `MRX_OFF_PC);
  assign wr_stk  = bus_wr && (wb_adr_i == `MRX_OFF_STACK);

  // execution strobes, each one instruction cycle
  wire        in_exec;
  wire        do_file;
  wire        do_ind;
  wire        do_pre;
  wire        do_rst;
  wire        do_ret;
  wire        do_ret_irq;
  wire        launch;
  wire [SP_W-1:0] sp_top;

  assign in_exec    = (state_q == MRX_ST_EXEC);
  assign do_file    = in_exec && (op == MRX_OP_TO_FILE);
  assign do_ind     = in_exec && ((op == MRX_OP_TO_IND) || (op == MRX_OP_TO_REL));
  assign do_pre     = in_exec && (op == MRX_OP_PRESCALE);
  assign do_rst     = in_exec && (op == MRX_OP_SOFT_RST);
  assign do_ret_irq = in_exec && (op == MRX_OP_RET_IRQ);
  assign do_ret     = do_ret_irq || (in_exec && (op == MRX_OP_RET_SUB));
  // a command written while busy is dropped; status shows busy
  assign launch     = wr_cmd && (state_q == MRX_ST_IDLE);
  assign sp_top     = sp_q - SP_W'(1);

  // pointer arithmetic
  mrx_ptr_if pif ();

  assign pif.ptr  = ptr_q[n_sel];
  assign pif.mode = mode;
  assign pif.rel  = (op == MRX_OP_TO_REL);
  assign pif.k    = k_opnd;

  mrx_ptr_unit u_ptr (
    .p (pif.calc)
  );

  // sequencer: returns spend a second cycle, all else one
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MRX_ST_IDLE: state_d = launch ? MRX_ST_EXEC : MRX_ST_IDLE;
      MRX_ST_EXEC: state_d = do_ret ? MRX_ST_SEC : MRX_ST_IDLE;
      MRX_ST_SEC:  state_d = MRX_ST_IDLE;
      default:     state_d = MRX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_rst)
      state_q <= MRX_ST_IDLE;
    else
      state_q <= state_d;
  end

  // command latch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      instr_q <= 32'h0000_0000;
    else if (launch)
      instr_q <= wb_dat_i;
  end

  // accumulator: only software writes it; soft reset clears it, no other instruction here changes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_rst)
      acc_q <= `MRX_RST_ACC;
    else if (wr_acc)
      acc_q <= wb_dat_i[7:0];
  end

  // pointers; write-back wins over a bus write in the same cycle, no flag path exists
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_rst)
    begin
      ptr_q[0] <= `MRX_RST_PTR;
      ptr_q[1] <= `MRX_RST_PTR;
    end
    else
    begin
      if (wr_ptr0)
        ptr_q[0] <= {lane1 ? wb_dat_i[15:8] : ptr_q[0][15:8], lane0 ? wb_dat_i[7:0] : ptr_q[0][7:0]};
      if (wr_ptr1)
        ptr_q[1] <= {lane1 ? wb_dat_i[15:8] : ptr_q[1][15:8], lane0 ? wb_dat_i[7:0] : ptr_q[1][7:0]};
      if (do_ind)
        ptr_q[n_sel] <= pif.nxt;
    end
  end

  // memory write port, registered so data leaves from flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_rst)
    begin
      mem_we_q  <= 1'b0;
      mem_adr_q <= 16'h0000;
      mem_dat_q <= 8'h00;
    end
    else
    begin
      mem_we_q  <= do_file || do_ind;
      mem_adr_q <= do_ind ? pif.ea : {9'h000, f_opnd};
      mem_dat_q <= acc_q;
    end
  end

  // timer prescale configuration
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_rst)
      prescale_q <= `MRX_RST_PRESCALE;
    else if (do_pre)
      prescale_q <= acc_q;
    else if (wr_pre)
      prescale_q <= wb_dat_i[7:0];
  end

  // interrupt control; the return's set wins over a same-cycle bus write
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_rst)
      irq_control_reg_q <= `MRX_RST_IRQCTL;
    else
    begin
      if (wr_irq)
        irq_control_reg_q <= wb_dat_i[7:0];
      if (do_ret_irq)
        irq_control_reg_q[`MRX_GIE_BIT] <= 1'b1;
    end
  end

  // power control survives soft reset so firmware can see the cause
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      power_control_reg_q <= `MRX_RST_PWRCTL;
    else
    begin
      if (wr_pwr)
        power_control_reg_q <= wb_dat_i[7:0];
      if (do_rst)
        power_control_reg_q[`MRX_SRF_BIT] <= 1'b0;
    end
  end

  // program counter: every completed instruction advances it except returns and soft reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_rst)
      pc_q <= `MRX_RST_PC;
    else if (do_ret)
      pc_q <= stack_q[sp_top];
    else if (in_exec)
      pc_q <= pc_q + PC_W'(1);
    else if (wr_pc)
      pc_q <= wb_dat_i[PC_W-1:0];
  end

  // return stack; software pushes, returns pop; the pointer wraps like a ring
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_rst)
      sp_q <= '0;
    else if (do_ret)
      sp_q <= sp_top;
    else if (wr_stk)
      sp_q <= sp_q + SP_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (wr_stk && !do_ret)
      stack_q[sp_q] <= wb_dat_i[PC_W-1:0];
  end

  // soft reset strobe to the rest of the chip
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      soft_reset_q <= 1'b0;
    else
      soft_reset_q <= do_rst;
  end

  // read mux; unmapped offsets read zero and still ack
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `MRX_OFF_CMD:      rd_mux = instr_q;
      `MRX_OFF_ACC:      rd_mux = {24'h000000, acc_q};
      `MRX_OFF_PTR0:     rd_mux = {16'h0000, ptr_q[0]};
      `MRX_OFF_PTR1:     rd_mux = {16'h0000, ptr_q[1]};
      `MRX_OFF_PRESCALE: rd_mux = {24'h000000, prescale_q};
      `MRX_OFF_IRQCTL:   rd_mux = {24'h000000, irq_control_reg_q};
      `MRX_OFF_PWRCTL:   rd_mux = {24'h000000, power_control_reg_q};
      `MRX_OFF_PC:       rd_mux = 32'(pc_q);
      `MRX_OFF_STACK:    rd_mux = 32'(stack_q[sp_top]);
      `MRX_OFF_STATUS:   rd_mux = {16'h0000, 8'(sp_q), 7'h00, (state_q != MRX_ST_IDLE)};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: ack in the cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= bus_req && !ack_q;
      if (bus_req && !ack_q)
        dat_q <= rd_mux;
    end
  end

  // outputs
  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = dat_q;
  assign mem_we_o            = mem_we_q;
  assign mem_adr_o           = mem_adr_q;
  assign mem_dat_o           = mem_dat_q;
  assign prescale_o          = prescale_q;
  assign global_irq_enable_o = irq_control_reg_q[`MRX_GIE_BIT];
  assign pc_o                = pc_q;
  assign soft_reset_o        = soft_reset_q;
  assign busy_o              = (state_q != MRX_ST_IDLE);

endmodule // mrx_exec

/* tb/mrx_exec_props.sv */
// checker for the move/return executor, bound to mrx_exec
// assumes the opcode sits in the low three bits of the command word
`timescale 1ns/1ns
`include "mrx_cfg.svh"
module mrx_exec_props
#(
  parameter int PC_W = 15
)
(
  // clock and reset
  input wire logic            clk_i,
  input wire logic            rst_i,
  // bus side
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [31:0]     wb_dat_i,
  input wire logic            wb_ack_o,
  // core side
  input wire logic            mem_we_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic            global_irq_enable_o,
  input wire logic            soft_reset_o,
  input wire logic            busy_o
);
  logic [2:0] op_q;
  wire        cmd_take = wb_ack_o && wb_we_i && (wb_adr_i == `MRX_OFF_CMD) && !busy_o;

  // last accepted opcode; refused writes while busy leave it alone
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      op_q <= 3'h0;
    else if (cmd_take)
      op_q <= wb_dat_i[2:0];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ret_busy; busy_o ##1 busy_o ##1 !busy_o; endsequence

  property p_ack; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_start; cmd_take |=> busy_o; endproperty
  property p_single; ($rose(busy_o) && op_q < 3'h5) |-> busy_o ##1 !busy_o; endproperty
  property p_ret; ($rose(busy_o) && op_q >= 3'h6) |-> s_ret_busy; endproperty
  property p_pc_next; ($fell(busy_o) && op_q < 3'h5) |-> pc_o == $past(pc_o) + 1'b1; endproperty
  property p_store; mem_we_o |-> $past(busy_o) && !busy_o; endproperty
  property p_store_once; mem_we_o |=> !mem_we_o; endproperty
  property p_no_store; ($rose(busy_o) && (op_q == 3'h0 || op_q >= 3'h4)) |-> ##1 !mem_we_o; endproperty
  property p_gie; ($fell(busy_o) && op_q == 3'h6) |-> global_irq_enable_o; endproperty
  property p_soft; ($rose(busy_o) && op_q == 3'h5) |-> ##[1:3] soft_reset_o; endproperty

  a_ack: assert property (p_ack) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_start: assert property (p_start) else $error("command not started");
  a_single: assert property (p_single) else $error("single cycle op took longer");
  a_ret: assert property (p_ret) else $error("return not two cycles");
  a_pc_next: assert property (p_pc_next) else $error("pc not advanced by one");
  a_store: assert property (p_store) else $error("store outside execution");
  a_store_once: assert property (p_store_once) else $error("store strobe too long");
  a_no_store: assert property (p_no_store) else $error("store by non storing op");
  a_gie: assert property (p_gie) else $error("irq return left enable clear");
  a_soft: assert property (p_soft) else $error("soft reset pulse missing");
endmodule // mrx_exec_props

/* tb/test_mrx_exec.sv */
// bench for the move/return executor: wishbone tasks, stores caught on the memory port
// assumes the register map and command layout of mrx_cfg.svh
`timescale 1ns/1ns
`include "mrx_cfg.svh"
module test_mrx_exec
  import mrx_pkg::*;
;
  // design pins
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        mem_we_o;
  logic [15:0] mem_adr_o;
  logic [7:0]  mem_dat_o;
  logic [7:0]  prescale_o;
  logic        global_irq_enable_o;
  logic [14:0] pc_o;
  logic        soft_reset_o;
  logic        busy_o;
  // bench state
  logic [15:0] st_adr;
  logic [7:0]  st_dat;
  int          st_n      = 0;
  int          sr_n      = 0;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycles    = 0;

  always #50 clk_i = ~clk_i;

  mrx_exec dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .mem_we_o, .mem_adr_o, .mem_dat_o, .prescale_o, .global_irq_enable_o,
    .pc_o, .soft_reset_o, .busy_o);

  // catch every store; the strobe lasts one cycle so it is sampled at each edge
  always @(posedge clk_i)
  begin
    cycles++;
    if (mem_we_o === 1'b1)
    begin
      st_adr <= mem_adr_o;
      st_dat <= mem_dat_o;
      st_n++;
    end
    // soft reset pulses, counted so the bench sees the strobe itself
    if (soft_reset_o === 1'b1)
      sr_n++;
    if (cycles == 5000)
    begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask

  // returns finish within four cycles of the command ack
  task automatic cmd(input mrx_op_t op, input logic [6:0] f, input logic n, input logic [1:0] m,
    input logic [5:0] k);
    wr(`MRX_OFF_CMD, {13'h0, k, m, n, f, op});
    repeat (4) @(posedge clk_i);
  endtask

  task automatic t_reset();
    rd("acc", `MRX_OFF_ACC, 32'h0);
    rd("ptr0", `MRX_OFF_PTR0, 32'h0);
    rd("ptr1", `MRX_OFF_PTR1, 32'h0);
    rd("pc", `MRX_OFF_PC, 32'h0);
    rd("prescale", `MRX_OFF_PRESCALE, 32'hff);
    rd("irqctl", `MRX_OFF_IRQCTL, 32'h0);
    rd("pwrctl", `MRX_OFF_PWRCTL, 32'hff);
    wr(8'h30, 32'hffffffff);
    rd("unmapped", 8'h30, 32'h0);
  endtask

  task automatic t_file();
    logic [14:0] p;
    int          n;
    wr(`MRX_OFF_ACC, 32'h5a);
    p = pc_o;
    n = st_n;
    cmd(MRX_OP_TO_FILE, 7'h7f, 1'b0, 2'b00, 6'h0);
    chk("stores", st_n, n + 1);
    chk("file adr", st_adr, 32'h7f);
    chk("file dat", st_dat, 32'h5a);
    chk("pc", pc_o, p + 1);
  endtask

  // each mode from the wrap boundary: 0000 for decrements, ffff for increments
  task automatic t_ind();
    logic [15:0] s;
    logic [15:0] nw;
    int          n;
    wr(`MRX_OFF_PTR0, 32'h1234);
    for (int m = 0; m < 4; m++)
    begin
      s  = m[0] ? 16'h0000 : 16'hffff;
      nw = m[0] ? 16'hffff : 16'h0000;
      wr(`MRX_OFF_PTR1, {16'h0, s});
      n = st_n;
      cmd(MRX_OP_TO_IND, 7'h0, 1'b1, m[1:0], 6'h0);
      chk("ind stores", st_n, n + 1);
      chk("ind adr", st_adr, m[1] ? s : nw);
      chk("ind dat", st_dat, 32'h5a);
      rd("ptr1", `MRX_OFF_PTR1, {16'h0, nw});
    end
    rd("ptr0", `MRX_OFF_PTR0, 32'h1234);
  endtask

  task automatic t_rel();
    wr(`MRX_OFF_PTR0, 32'h10);
    cmd(MRX_OP_TO_REL, 7'h0, 1'b0, 2'b00, 6'h20);
    chk("rel low", st_adr, 32'hfff0);
    cmd(MRX_OP_TO_REL, 7'h0, 1'b0, 2'b00, 6'h1f);
    chk("rel high", st_adr, 32'h2f);
    rd("ptr0 kept", `MRX_OFF_PTR0, 32'h10);
  endtask

  task automatic t_idle_pre();
    logic [14:0] p;
    int          n;
    p = pc_o;
    n = st_n;
    cmd(MRX_OP_IDLE, 7'h0, 1'b0, 2'b00, 6'h0);
    chk("idle pc", pc_o, p + 1);
    chk("idle stores", st_n, n);
    wr(`MRX_OFF_ACC, 32'h4f);
    cmd(MRX_OP_PRESCALE, 7'h0, 1'b0, 2'b00, 6'h0);
    chk("prescale", prescale_o, 32'h4f);
    rd("prescale reg", `MRX_OFF_PRESCALE, 32'h4f);
  endtask

  task automatic t_ret();
    wr(`MRX_OFF_STACK, 32'h1234);
    wr(`MRX_OFF_STACK, 32'h0abc);
    rd("stack top", `MRX_OFF_STACK, 32'h0abc);
    cmd(MRX_OP_RET_IRQ, 7'h0, 1'b0, 2'b00, 6'h0);
    chk("irq ret pc", pc_o, 32'h0abc);
    chk("gie", global_irq_enable_o, 32'h1);
    rd("irqctl", `MRX_OFF_IRQCTL, 32'h80);
    rd("status", `MRX_OFF_STATUS, 32'h100);
    cmd(MRX_OP_RET_SUB, 7'h0, 1'b0, 2'b00, 6'h0);
    chk("sub ret pc", pc_o, 32'h1234);
    rd("status", `MRX_OFF_STATUS, 32'h0);
  endtask

  task automatic t_soft();
    wr(`MRX_OFF_ACC, 32'h5a);
    cmd(MRX_OP_SOFT_RST, 7'h0, 1'b0, 2'b00, 6'h0);
    rd("pwrctl", `MRX_OFF_PWRCTL, 32'hfb);
    rd("acc", `MRX_OFF_ACC, 32'h0);
    chk("pc", pc_o, 32'h0);
    chk("gie", global_irq_enable_o, 32'h0);
    chk("soft pulses", sr_n, 32'h1);
  endtask

  // reset for four cycles, then each scenario in turn
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_file();
    t_ind();
    t_rel();
    t_idle_pre();
    t_ret();
    t_soft();
    test_done();
  end
endmodule // test_mrx_exec

bind mrx_exec mrx_exec_props #(.PC_W(PC_W)) u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .mem_we_o(mem_we_o), .pc_o(pc_o), .global_irq_enable_o(global_irq_enable_o),
  .soft_reset_o(soft_reset_o), .busy_o(busy_o));
